// file: adc_cmp_pkg.sv
// Shared constants, register map and carrier types for the dual channel converter block
package adc_cmp_pkg;
  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Register byte offsets
  localparam logic [7:0] OFS_CH0_CFG = 8'h00;
  localparam logic [7:0] OFS_CH1_CFG = 8'h04;
  localparam logic [7:0] OFS_START = 8'h08;
  localparam logic [7:0] OFS_RESULT0 = 8'h0c;
  localparam logic [7:0] OFS_RESULT1 = 8'h10;
  localparam logic [7:0] OFS_CMP_CFG = 8'h14;
  localparam logic [7:0] OFS_CMP_CONST = 8'h18;
  localparam logic [7:0] OFS_CMP_STATUS = 8'h1c;
  localparam logic [7:0] OFS_INT_STATUS = 8'h20;
  localparam logic [7:0] OFS_INT_ENABLE = 8'h24;
  localparam logic [7:0] OFS_INT_CLEAR = 8'h28;
  // Channel configuration fields
  localparam int SEL_POS = 0;
  localparam int SEL_W = 5;
  localparam int SAMP_POS = 5;
  localparam int SAMP_W = 3;
  localparam int PREC_POS = 8;
  localparam int PREC_W = 2;
  localparam int CFG_W = 10;
  localparam logic [9:0] CFG_RST = 10'h000;
  // Result register layout
  localparam int VAL_W = 12;
  localparam int RES_W = 16;
  localparam int DONE_POS = 15;
  // Comparator configuration fields
  localparam int CMP_EN_POS = 0;
  localparam int CMP_ASRC_POS = 1;
  localparam int CMP_BSRC_POS = 2;
  localparam int CMP_TYPE_POS = 3;
  localparam int CMP_TYPE_W = 3;
  localparam int CMP_UPD_POS = 6;
  localparam int CMP_CFG_W = 7;
  localparam logic [6:0] CMP_CFG_RST = 7'h00;
  localparam logic [11:0] CMP_CONST_RST = 12'h000;
  // Comparison type codes
  localparam logic [2:0] CMP_GT = 3'h0;
  localparam logic [2:0] CMP_GE = 3'h1;
  localparam logic [2:0] CMP_LT = 3'h2;
  localparam logic [2:0] CMP_LE = 3'h3;
  localparam logic [2:0] CMP_EQ = 3'h4;
  // Interrupt event bits
  localparam int EV_CH0 = 0;
  localparam int EV_CH1 = 1;
  localparam int EV_CMP = 2;
  localparam int EV_W = 3;
  localparam logic [2:0] INT_EN_RST = 3'h0;
  // Analog inputs 16 to 31 are the general purpose pins
  localparam int GPIO_FIRST = 16;
  localparam int GPIO_N = 16;
  // Sample time base and its cycle count at 50 MHz
  localparam int CLK_PERIOD_NS = 20;
  localparam int SAMPLE_BASE_NS = 100;
  localparam int SAMPLE_BASE_CYCLES = (SAMPLE_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {CH_IDLE, CH_SAMPLE, CH_CONVERT} chan_state_t;

  // Request to the analog converter macro, one per channel
  typedef struct packed {
    logic sample;
    logic convert;
    logic [4:0] sel;
    logic [1:0] prec;
  } adc_req_t;

  // Answer from the analog converter macro
  typedef struct packed {
    logic done;
    logic [11:0] data;
  } adc_rsp_t;

  // Precision code to kept result bits: 12, 10, 8 or 6 bits
  function automatic logic [11:0] prec_mask(input logic [1:0] prec);
    logic [11:0] m;
    m = 12'hfff;
    unique case (prec)
      2'h0: m = 12'hfff;
      2'h1: m = 12'hffc;
      2'h2: m = 12'hff0;
      2'h3: m = 12'hfc0;
    endcase
    return m;
  endfunction : prec_mask

  // Byte strobes to a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction : strb_mask
endpackage : adc_cmp_pkg

// file: adc_dual_channel_comparator.sv
// Dual channel converter control with digital comparator behind an AXI4-Lite slave
//
// Summary of operation
// RULE1: Two channels, each selecting among 32 inputs
// RULE2: Per channel input, sample time, precision settable
// RULE3: Separate start trigger for each channel
// RULE4: Result top bit is done, rest value
// RULE5: Configuration, starts and results reachable over bus
// RULE6: General purpose pins selectable as analog inputs
// RULE7: Comparator types gt, ge, lt, le, eq
// RULE8: Reference is constant or other channel result
// RULE9: Operand sources, update, type, enable configurable
// RULE10: Comparison outcome readable over the bus
// RULE11: Start clears done until new result
// RULE12: Disabled comparator reads false, ignores updates
`timescale 1ns/10ps
module adc_dual_channel_comparator (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  // AXI4-Lite write channels
  input wire logic [7:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  // AXI4-Lite read channels
  input wire logic [7:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  // Analog converter macro
  output adc_cmp_pkg::adc_req_t [1:0] O_ADC_REQ,
  input wire adc_cmp_pkg::adc_rsp_t [1:0] I_ADC_RSP,
  // Analog path enables of the general purpose pins
  output logic [15:0] O_GPIO_ANALOG_EN,
  // Comparator outcome and interrupt
  output logic O_CMP_OUT,
  output logic O_IRQ
);
  import adc_cmp_pkg::*;

  // Bus state
  logic aw_held, next_aw_held;
  logic [7:0] aw_addr, next_aw_addr;
  logic w_held, next_w_held;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;
  // Software registers
  logic [CFG_W-1:0] cfg [2];
  logic [CFG_W-1:0] next_cfg [2];
  logic [CMP_CFG_W-1:0] cmp_cfg, next_cmp_cfg;
  logic [11:0] cmp_const, next_cmp_const;
  logic [EV_W-1:0] int_en, next_int_en;
  logic [EV_W-1:0] int_status, next_int_status;
  // Decoded write and channel signals
  logic do_write;
  logic [31:0] wmask;
  logic [31:0] wbits;
  logic [1:0] start;
  logic [EV_W-1:0] int_clr;
  logic [1:0] conv_done;
  logic [1:0] res_done;
  logic [11:0] res_value [2];
  logic [31:0] rd_word;
  logic rd_ok;
  // Comparator wiring
  logic a_ch;
  logic [11:0] op_a, op_b;
  logic cmp_upd, next_cmp_upd;
  logic cmp_out, cmp_rise;

  // Handshake readies, one item held at a time
  assign O_AWREADY = !aw_held && !bvalid;
  assign O_WREADY = !w_held && !bvalid;
  assign O_ARREADY = !rvalid;
  assign do_write = aw_held && w_held && !bvalid;
  assign wmask = strb_mask(w_strb);
  assign wbits = w_data & wmask;

  // Write pulses for start and interrupt clear
  always_comb begin
    start = 2'h0;
    int_clr = '0;
    if (do_write && aw_addr == OFS_START) begin
      // RULE3 independent start bits
      start = wbits[1:0];
    end
    if (do_write && aw_addr == OFS_INT_CLEAR) begin
      int_clr = wbits[EV_W-1:0];
    end
  end

  // Read decode
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    // Low address bits ignored, as on the write side
    unique case ({I_ARADDR[7:2], 2'h0})
      OFS_CH0_CFG: rd_word = 32'(cfg[0]);
      OFS_CH1_CFG: rd_word = 32'(cfg[1]);
      OFS_START: rd_word = 32'h0000_0000;
      // RULE4 done flag above value
      OFS_RESULT0: rd_word = 32'({res_done[0], 3'h0, res_value[0]});
      OFS_RESULT1: rd_word = 32'({res_done[1], 3'h0, res_value[1]});
      OFS_CMP_CFG: rd_word = 32'(cmp_cfg);
      OFS_CMP_CONST: rd_word = 32'(cmp_const);
      // RULE10 outcome readback
      OFS_CMP_STATUS: rd_word = 32'(cmp_out);
      OFS_INT_STATUS: rd_word = 32'(int_status);
      OFS_INT_ENABLE: rd_word = 32'(int_en);
      OFS_INT_CLEAR: rd_word = 32'h0000_0000;
      default: rd_ok = 1'b0;
    endcase
  end

  // Bus and register next values
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    next_cfg = cfg;
    next_cmp_cfg = cmp_cfg;
    next_cmp_const = cmp_const;
    next_int_en = int_en;
    if (I_AWVALID && O_AWREADY) begin
      next_aw_held = 1'b1;
      next_aw_addr = {I_AWADDR[7:2], 2'h0};
    end
    if (I_WVALID && O_WREADY) begin
      next_w_held = 1'b1;
      next_w_data = I_WDATA;
      next_w_strb = I_WSTRB;
    end
    if (bvalid && I_BREADY) begin
      next_bvalid = 1'b0;
    end
    // RULE5 register writes
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      unique case (aw_addr)
        // RULE2 per channel settings
        OFS_CH0_CFG: next_cfg[0] = (cfg[0] & ~wmask[CFG_W-1:0]) | wbits[CFG_W-1:0];
        OFS_CH1_CFG: next_cfg[1] = (cfg[1] & ~wmask[CFG_W-1:0]) | wbits[CFG_W-1:0];
        // RULE9 comparator controls
        OFS_CMP_CFG: next_cmp_cfg = (cmp_cfg & ~wmask[CMP_CFG_W-1:0]) | wbits[CMP_CFG_W-1:0];
        OFS_CMP_CONST: next_cmp_const = (cmp_const & ~wmask[11:0]) | wbits[11:0];
        OFS_INT_ENABLE: next_int_en = (int_en & ~wmask[EV_W-1:0]) | wbits[EV_W-1:0];
        OFS_START, OFS_RESULT0, OFS_RESULT1, OFS_CMP_STATUS,
        OFS_INT_STATUS, OFS_INT_CLEAR: next_bresp = RESP_OKAY;
        default: next_bresp = RESP_SLVERR;
      endcase
    end
    if (rvalid && I_RREADY) begin
      next_rvalid = 1'b0;
    end
    if (I_ARVALID && O_ARREADY) begin
      next_rvalid = 1'b1;
      next_rdata = rd_word;
      next_rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Bus and register flops
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
      cfg[0] <= CFG_RST;
      cfg[1] <= CFG_RST;
      cmp_cfg <= CMP_CFG_RST;
      cmp_const <= CMP_CONST_RST;
      int_en <= INT_EN_RST;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      cfg <= next_cfg;
      cmp_cfg <= next_cmp_cfg;
      cmp_const <= next_cmp_const;
      int_en <= next_int_en;
    end
  end

  assign O_BVALID = bvalid;
  assign O_BRESP = bresp;
  assign O_RVALID = rvalid;
  assign O_RDATA = rdata;
  assign O_RRESP = rresp;

  // Per channel sequencer: sample phase, then conversion in the macro
  for (genvar g = 0; g < 2; g++) begin : g_chan
    chan_state_t state, next_state;
    logic [9:0] cnt, next_cnt;
    logic [11:0] value, next_value;
    logic done, next_done;
    logic [4:0] sel, next_sel;
    logic [1:0] prec, next_prec;
    logic [9:0] samp_cycles;

    assign samp_cycles = 10'(SAMPLE_BASE_CYCLES) << cfg[g][SAMP_POS +: SAMP_W];
    assign conv_done[g] = (state == CH_CONVERT) && I_ADC_RSP[g].done;

    always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_value = value;
      next_done = done;
      next_sel = sel;
      next_prec = prec;
      unique case (state)
        CH_IDLE: begin
          if (start[g]) begin
            next_state = CH_SAMPLE;
            next_cnt = samp_cycles - 10'h001;
            // RULE11 done cleared on start
            next_done = 1'b0;
            // RULE1 five bit input select
            next_sel = cfg[g][SEL_POS +: SEL_W];
            next_prec = cfg[g][PREC_POS +: PREC_W];
          end
        end
        CH_SAMPLE: begin
          if (cnt == 10'h000) begin
            next_state = CH_CONVERT;
          end else begin
            next_cnt = cnt - 10'h001;
          end
        end
        CH_CONVERT: begin
          if (I_ADC_RSP[g].done) begin
            next_state = CH_IDLE;
            // RULE4 value and done set together
            next_value = I_ADC_RSP[g].data & prec_mask(prec);
            next_done = 1'b1;
          end
        end
      endcase
    end

    always_ff @(posedge I_CLK) begin
      if (!I_RESET_N) begin
        state <= CH_IDLE;
        cnt <= 10'h000;
        value <= 12'h000;
        done <= 1'b0;
        sel <= 5'h00;
        prec <= 2'h0;
      end else begin
        state <= next_state;
        cnt <= next_cnt;
        value <= next_value;
        done <= next_done;
        sel <= next_sel;
        prec <= next_prec;
      end
    end

    assign res_done[g] = done;
    assign res_value[g] = value;
    assign O_ADC_REQ[g].sample = (state == CH_SAMPLE);
    assign O_ADC_REQ[g].convert = (state == CH_CONVERT);
    assign O_ADC_REQ[g].sel = sel;
    assign O_ADC_REQ[g].prec = prec;

    start_clears_done_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // RULE11
      start[g] && state == CH_IDLE |=> !done && state == CH_SAMPLE)
      else $error("start did not clear done flag");
    result_sets_done_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // RULE4
      conv_done[g] |=> done && value == ($past(I_ADC_RSP[g].data) & prec_mask(prec)))
      else $error("result not stored with done flag");
    sample_length_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // RULE2
      state == CH_IDLE && start[g] && cfg[g][SAMP_POS +: SAMP_W] == 3'h0 |=>
      O_ADC_REQ[g].sample [*5] ##1 O_ADC_REQ[g].convert)
      else $error("sample phase length wrong");
  end

  // GPIO analog path enabled when either channel selects the pin
  for (genvar p = 0; p < GPIO_N; p++) begin : g_gpio
    // RULE6 pin as analog input
    assign O_GPIO_ANALOG_EN[p] = (cfg[0][SEL_POS +: SEL_W] == 5'(GPIO_FIRST + p)) ||
                                 (cfg[1][SEL_POS +: SEL_W] == 5'(GPIO_FIRST + p));
  end

  // Comparator operands and update strobe
  always_comb begin
    a_ch = cmp_cfg[CMP_ASRC_POS];
    op_a = a_ch ? res_value[1] : res_value[0];
    // RULE8 constant or other channel
    op_b = cmp_cfg[CMP_BSRC_POS] ? (a_ch ? res_value[0] : res_value[1]) : cmp_const;
    // RULE9 update on operand channel or either
    next_cmp_upd = cmp_cfg[CMP_UPD_POS] ? (|conv_done) : conv_done[a_ch];
  end

  // Update strobe delayed so the new result is already stored
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      cmp_upd <= 1'b0;
    end else begin
      cmp_upd <= next_cmp_upd;
    end
  end

  value_comparator u_cmp (
    .i_clk(I_CLK),
    .i_reset_n(I_RESET_N),
    .i_enable(cmp_cfg[CMP_EN_POS]),
    .i_type(cmp_cfg[CMP_TYPE_POS +: CMP_TYPE_W]),
    .i_update(cmp_upd),
    .i_a(op_a),
    .i_b(op_b),
    .o_outcome(cmp_out),
    .o_rise(cmp_rise)
  );

  assign O_CMP_OUT = cmp_out;

  // Sticky interrupt status, a new event wins over a clear
  always_comb begin
    next_int_status = (int_status & ~int_clr) | {cmp_rise, conv_done};
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      int_status <= '0;
    end else begin
      int_status <= next_int_status;
    end
  end

  assign O_IRQ = |(int_status & int_en);

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);

  write_response_a: assert property ( // RULE5
    aw_held && w_held && !bvalid |=> O_BVALID ##1 (O_BVALID || $past(I_BREADY)))
    else $error("write response missing");
  start_independent_a: assert property ( // RULE3
    start == 2'h1 && g_chan[1].state == CH_IDLE |=> g_chan[1].state == CH_IDLE)
    else $error("start of channel zero launched channel one");
  status_readback_a: assert property ( // RULE10
    I_ARVALID && O_ARREADY && I_ARADDR == OFS_CMP_STATUS |=>
    O_RVALID && O_RDATA == 32'($past(cmp_out)))
    else $error("comparator status read wrong");
  const_reference_a: assert property ( // RULE8
    !cmp_cfg[CMP_BSRC_POS] |-> op_b == cmp_const)
    else $error("constant reference not used");
  gpio_select_a: assert property ( // RULE6
    cfg[0][SEL_POS +: SEL_W] == 5'h14 |-> O_GPIO_ANALOG_EN[4])
    else $error("selected pin analog path off");
  compare_update_a: assert property ( // RULE9
    conv_done[0] && !cmp_cfg[CMP_ASRC_POS] && !cmp_cfg[CMP_UPD_POS] |=> cmp_upd)
    else $error("update strobe missing");
  sticky_event_a: assert property ( // RULE4
    conv_done[0] |=> int_status[EV_CH0])
    else $error("conversion event not recorded");
endmodule : adc_dual_channel_comparator

// file: adc_macro_model.sv
// Behavioural model of the analog converter macro on the far side of the block
`timescale 1ns/10ps
module adc_macro_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Requests from the block
  input wire adc_cmp_pkg::adc_req_t [1:0] i_req,
  // Values to return and answer delay per channel
  input wire logic [1:0][11:0] i_value,
  input wire logic [1:0][3:0] i_delay,
  // Answers to the block
  output adc_cmp_pkg::adc_rsp_t [1:0] o_rsp
);
  import adc_cmp_pkg::*;
  logic [1:0][3:0] wait_cnt;

  // Answer after the delay; data toggles while not valid so a stale value is not held
  always_ff @(posedge i_clk) begin
    for (int c = 0; c < 2; c++) begin
      if (!i_reset_n) begin
        wait_cnt[c] <= 4'h0;
        o_rsp[c] <= '0;
      end else if (i_req[c].convert && !o_rsp[c].done) begin
        if (wait_cnt[c] >= i_delay[c]) begin
          o_rsp[c].done <= 1'b1;
          o_rsp[c].data <= i_value[c];
          wait_cnt[c] <= 4'h0;
        end else begin
          wait_cnt[c] <= wait_cnt[c] + 4'h1;
          o_rsp[c].data <= ~o_rsp[c].data;
        end
      end else begin
        o_rsp[c].done <= 1'b0;
        o_rsp[c].data <= ~o_rsp[c].data;
        wait_cnt[c] <= 4'h0;
      end
    end
  end
endmodule : adc_macro_model

// file: testbench.sv
// Self-checking bench for the dual channel converter block
`timescale 1ns/10ps
`define CHECK(nm, exp, act) begin n_tests++; if ((act) !== (exp)) begin fail_count++; \
  $display("ERROR %s expected %h seen %h", nm, exp, act); end end
module testbench;
  import adc_cmp_pkg::*;
  logic I_CLK = 1'b0;
  logic I_RESET_N = 1'b0;
  logic [7:0] I_AWADDR = 8'h00, I_ARADDR = 8'h00;
  logic I_AWVALID = 1'b0, I_WVALID = 1'b0, I_BREADY = 1'b0, I_ARVALID = 1'b0, I_RREADY = 1'b0;
  logic [31:0] I_WDATA = 32'h0;
  logic [3:0] I_WSTRB = 4'h0;
  logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_CMP_OUT, O_IRQ;
  logic [1:0] O_BRESP, O_RRESP, rsp;
  logic [31:0] O_RDATA, rd;
  adc_req_t [1:0] O_ADC_REQ;
  adc_rsp_t [1:0] I_ADC_RSP;
  logic [15:0] O_GPIO_ANALOG_EN, r;
  logic [1:0][11:0] val = '0;
  logic [1:0][3:0] dly = {4'h0, 4'h3};
  int fail_count = 0;
  int n_tests = 0;

  // Clock
  always #10 I_CLK = ~I_CLK;

  // Block and its converter macro
  adc_dual_channel_comparator DUT (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N),
    .I_AWADDR(I_AWADDR), .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY), .I_WDATA(I_WDATA),
    .I_WSTRB(I_WSTRB), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BRESP(O_BRESP),
    .O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .I_ARADDR(I_ARADDR), .I_ARVALID(I_ARVALID),
    .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA), .O_RRESP(O_RRESP), .O_RVALID(O_RVALID),
    .I_RREADY(I_RREADY), .O_ADC_REQ(O_ADC_REQ), .I_ADC_RSP(I_ADC_RSP),
    .O_GPIO_ANALOG_EN(O_GPIO_ANALOG_EN), .O_CMP_OUT(O_CMP_OUT), .O_IRQ(O_IRQ));
  adc_macro_model macro (.i_clk(I_CLK), .i_reset_n(I_RESET_N), .i_req(O_ADC_REQ),
    .i_value(val), .i_delay(dly), .o_rsp(I_ADC_RSP));

  // One bus transfer; readies sampled mid-cycle, acted on at the next edge
  task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    logic aw, w, ar, fin;
    @(posedge I_CLK);
    if (wr) begin
      I_AWADDR <= a;
      I_WDATA <= d;
      I_WSTRB <= 4'hf;
      I_AWVALID <= 1'b1;
      I_WVALID <= 1'b1;
      I_BREADY <= 1'b1;
    end else begin
      I_ARADDR <= a;
      I_ARVALID <= 1'b1;
      I_RREADY <= 1'b1;
    end
    k = 0;
    fin = 1'b0;
    while (!fin && k < 100) begin
      @(negedge I_CLK);
      aw = I_AWVALID && O_AWREADY;
      w = I_WVALID && O_WREADY;
      ar = I_ARVALID && O_ARREADY;
      fin = (I_BREADY && O_BVALID) || (I_RREADY && O_RVALID);
      rsp = wr ? O_BRESP : O_RRESP;
      rd = O_RDATA;
      @(posedge I_CLK);
      if (aw) I_AWVALID <= 1'b0;
      if (w) I_WVALID <= 1'b0;
      if (ar) I_ARVALID <= 1'b0;
      if (fin) I_BREADY <= 1'b0;
      if (fin) I_RREADY <= 1'b0;
      k++;
    end
    `CHECK("bus answer", 1'b1, fin)
  endtask : bus

  // Read and compare one register
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    `CHECK("read resp", RESP_OKAY, rsp)
    `CHECK("read data", exp, rd)
  endtask : rchk

  // Start one channel and poll its result until done
  task automatic conv(input int ch, input logic [4:0] sel);
    int k;
    bus(1'b1, OFS_START, 32'h1 << ch);
    @(negedge I_CLK);
    `CHECK("sampling", 1'b1, O_ADC_REQ[ch].sample)
    `CHECK("input sel", sel, O_ADC_REQ[ch].sel)
    `CHECK("other idle", 1'b0, O_ADC_REQ[1-ch].sample | O_ADC_REQ[1-ch].convert)
    bus(1'b0, (ch == 0) ? OFS_RESULT0 : OFS_RESULT1, 32'h0);
    `CHECK("done cleared", 1'b0, rd[15])
    k = 0;
    while (rd[15] !== 1'b1 && k < 60) begin
      bus(1'b0, (ch == 0) ? OFS_RESULT0 : OFS_RESULT1, 32'h0);
      k++;
    end
    `CHECK("done set", 1'b1, rd[15])
    r = rd[15:0];
    repeat (4) @(posedge I_CLK);
  endtask : conv

  // Expected comparator outcome
  function automatic logic cmp_exp(input logic [2:0] t, input logic [11:0] a, b);
    case (t)
      CMP_GT: return a > b;
      CMP_GE: return a >= b;
      CMP_LT: return a < b;
      CMP_LE: return a <= b;
      CMP_EQ: return a == b;
      default: return 1'b0;
    endcase
  endfunction : cmp_exp

  // Reset values, unmapped address and field widths
  task automatic t_reset();
    `CHECK("cmp out", 1'b0, O_CMP_OUT)
    `CHECK("gpio en", 16'h0, O_GPIO_ANALOG_EN)
    rchk(OFS_CMP_CFG, 32'h0);
    bus(1'b1, 8'h30, 32'h1);
    `CHECK("write unmapped", RESP_SLVERR, rsp)
    bus(1'b0, 8'h30, 32'h0);
    `CHECK("read unmapped", RESP_SLVERR, rsp)
    bus(1'b1, OFS_CH1_CFG, 32'hffff_ffff);
    rchk(OFS_CH1_CFG, 32'h3ff);
    $display("test reset done");
  endtask : t_reset

  // Every precision on a pin input of channel zero
  task automatic t_chan();
    val[0] <= 12'habc;
    for (int p = 0; p < 4; p++) begin
      bus(1'b1, OFS_CH0_CFG, {22'h0, p[1:0], 3'h1, 5'd20});
      @(negedge I_CLK);
      `CHECK("gpio en", 16'h8010, O_GPIO_ANALOG_EN)
      conv(0, 5'd20);
      `CHECK("result", {1'b1, 3'h0, 12'habc & (12'hfff << (2 * p))}, r)
      `CHECK("prec", p[1:0], O_ADC_REQ[0].prec)
    end
    $display("test channel done");
  endtask : t_chan

  // Interrupt raise, mask and clear
  task automatic t_irq();
    bus(1'b1, OFS_INT_CLEAR, 32'h7);
    bus(1'b1, OFS_INT_ENABLE, 32'h1);
    conv(0, 5'd20);
    `CHECK("irq set", 1'b1, O_IRQ)
    rchk(OFS_INT_STATUS, 32'h1);
    bus(1'b1, OFS_INT_ENABLE, 32'h0);
    `CHECK("irq masked", 1'b0, O_IRQ)
    bus(1'b1, OFS_INT_ENABLE, 32'h1);
    bus(1'b1, OFS_INT_CLEAR, 32'h1);
    @(negedge I_CLK);
    `CHECK("irq cleared", 1'b0, O_IRQ)
    $display("test interrupt done");
  endtask : t_irq

  // Comparator types, reference sources, update and enable
  task automatic t_cmp();
    bus(1'b1, OFS_CH0_CFG, 32'h1);
    bus(1'b1, OFS_CH1_CFG, 32'h2);
    bus(1'b1, OFS_CMP_CONST, 32'h400);
    for (int t = 0; t < 5; t++) begin
      for (int i = 0; i < 3; i++) begin
        bus(1'b1, OFS_CMP_CFG, {25'h0, 1'b0, t[2:0], 2'b00, 1'b1});
        val[0] <= 12'h3ff + 12'(i);
        conv(0, 5'd1);
        rchk(OFS_CMP_STATUS, {31'h0, cmp_exp(t[2:0], val[0], 12'h400)});
        `CHECK("cmp pin", cmp_exp(t[2:0], val[0], 12'h400), O_CMP_OUT)
      end
    end
    val[1] <= 12'h200;
    conv(1, 5'd2);
    bus(1'b1, OFS_CMP_CFG, 32'h5);
    val[0] <= 12'h201;
    conv(0, 5'd1);
    `CHECK("other channel", 1'b1, O_CMP_OUT)
    bus(1'b1, OFS_CMP_CFG, 32'h45);
    val[1] <= 12'h300;
    conv(1, 5'd2);
    `CHECK("either update", 1'b0, O_CMP_OUT)
    bus(1'b1, OFS_CMP_CFG, 32'h5);
    val[0] <= 12'h301;
    conv(0, 5'd1);
    `CHECK("enabled", 1'b1, O_CMP_OUT)
    rchk(OFS_INT_STATUS, 32'h7);
    bus(1'b1, OFS_CMP_CFG, 32'h4);
    @(negedge I_CLK);
    `CHECK("disabled", 1'b0, O_CMP_OUT)
    conv(0, 5'd1);
    rchk(OFS_CMP_STATUS, 32'h0);
    $display("test comparator done");
  endtask : t_cmp

  // Verdict and end of run
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  // Main sequence
  initial begin
    repeat (12) @(posedge I_CLK);
    I_RESET_N <= 1'b1;
    @(negedge I_CLK);
    t_reset();
    t_chan();
    t_irq();
    t_cmp();
    final_report();
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge I_CLK);
    fail_count++;
    final_report();
  end
endmodule : testbench

// file: value_comparator.sv
// Digital comparator with selectable type, update strobe and enable
`timescale 1ns/10ps
module value_comparator (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Control
  input wire logic i_enable,
  input wire logic [2:0] i_type,
  input wire logic i_update,
  // Operands
  input wire logic [11:0] i_a,
  input wire logic [11:0] i_b,
  // Outcome
  output logic o_outcome,
  output logic o_rise
);
  import adc_cmp_pkg::*;

  logic outcome, next_outcome;
  logic rise, next_rise;
  logic hit;

  // Relation selected by the type code
  always_comb begin
    hit = 1'b0;
    unique case (i_type)
      CMP_GT: hit = i_a > i_b;
      CMP_GE: hit = i_a >= i_b;
      CMP_LT: hit = i_a < i_b;
      CMP_LE: hit = i_a <= i_b;
      CMP_EQ: hit = i_a == i_b;
      default: hit = 1'b0;
    endcase
  end

  // Next outcome and rising event
  always_comb begin
    next_outcome = outcome;
    // RULE12 forced false when off
    if (!i_enable) begin
      next_outcome = 1'b0;
    end else if (i_update) begin
      // RULE7 five comparison types
      next_outcome = hit;
    end
    next_rise = next_outcome && !outcome;
  end

  // Outcome registers
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      outcome <= 1'b0;
      rise <= 1'b0;
    end else begin
      outcome <= next_outcome;
      rise <= next_rise;
    end
  end

  assign o_outcome = outcome;
  assign o_rise = rise;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  disabled_holds_false_a: assert property ( // RULE12
    !i_enable |=> !o_outcome ##1 (!o_outcome || $past(i_enable)))
    else $error("comparator outcome not false while disabled");
  greater_than_a: assert property ( // RULE7
    i_enable && i_update && i_type == CMP_GT |=> o_outcome == ($past(i_a) > $past(i_b)))
    else $error("greater than outcome wrong");
  equal_type_a: assert property ( // RULE7
    i_enable && i_update && i_type == CMP_EQ |=> o_outcome == ($past(i_a) == $past(i_b)))
    else $error("equal outcome wrong");
  hold_no_update_a: assert property ( // RULE9
    i_enable && !i_update |=> $stable(o_outcome))
    else $error("outcome changed without update");
endmodule : value_comparator
